// [bench/tb.sv]
// self-checking bench for the baud rate generator
// assumes the design package is compiled first; one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic clock_enable_in = 1'b1;
    logic [2:0] address_in = 3'h0;
    logic [7:0] write_data_in = 8'h00;
    logic write_in = 1'b0;
    logic read_in = 1'b0;
    logic receiver_idle_in = 1'b1;
    logic [7:0] read_data_out;
    logic baud_tick_out;
    logic bit_tick_out;
    logic wide_counter_out;
    logic sync_mode_out;
    int failures = 0;
    int samples_checked = 0;

    baud_rate_generator dut_u (
        .clock_in(clock_in), .reset_in(reset_in),
        .clock_enable_in(clock_enable_in),
        .address_in(address_in), .write_data_in(write_data_in),
        .write_in(write_in), .read_in(read_in),
        .receiver_idle_in(receiver_idle_in), .read_data_out(read_data_out),
        .baud_tick_out(baud_tick_out), .bit_tick_out(bit_tick_out),
        .wide_counter_out(wide_counter_out), .sync_mode_out(sync_mode_out));

    always #4 clock_in = ~clock_in;

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_count(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_in);
        write_in <= 1'b1;
        address_in <= a;
        write_data_in <= d;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_in);
        read_in <= 1'b1;
        address_in <= a;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1 d = read_data_out;
    endtask

    // cycles until the next tick; bit_sel picks the scaled tick
    task automatic to_tick(input bit bit_sel, output int n);
        n = 0;
        do begin
            @(posedge clock_in);
            #1 n++;
        end while ((bit_sel ? bit_tick_out : baud_tick_out) !== 1'b1
                   && n < 20000);
    endtask

    // cycles from one tick to the next
    task automatic period(input bit bit_sel, output int n);
        to_tick(bit_sel, n);
        to_tick(bit_sel, n);
    endtask

    task automatic test_reset;
        logic [7:0] d;
        for (int a = 0; a < 4; a++) begin
            rd(a[2:0], d);
            cmp_byte(d, 8'h00);
        end
        rd(3'h5, d);
        cmp_byte(d, 8'h00);
        @(posedge clock_in);
        #1 cmp_byte(read_data_out, 8'h00);
        cmp_byte({6'h00, wide_counter_out, sync_mode_out}, 8'h00);
        rd(3'h4, d);
        cmp_byte(d & 8'hc0, 8'h80);
        $display("test reset done");
    endtask

    task automatic test_narrow;
        int n;
        wr(3'h0, 8'h02);
        period(1'b0, n);
        cmp_count(n, 3);
        period(1'b1, n);
        cmp_count(n, 3 * 64);
        $display("test narrow done");
    endtask

    task automatic test_wide;
        int n;
        wr(3'h1, 8'h01);
        wr(3'h0, 8'h02);
        period(1'b0, n);
        cmp_count(n, 3);
        wr(3'h2, 8'h08);
        @(posedge clock_in);
        #1 cmp_byte({7'h00, wide_counter_out}, 8'h01);
        wr(3'h0, 8'h02);
        period(1'b0, n);
        cmp_count(n, 259);
        $display("test wide done");
    endtask

    // {sync, high speed, wide} against the bit tick multiplier
    task automatic test_modes;
        int n;
        logic [2:0] mode [6] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b100,
                                 3'b110};
        int mult [6] = '{64, 16, 16, 4, 4, 4};
        wr(3'h1, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(3'h2, {4'h0, mode[i][0], 3'h0});
            wr(3'h3, {3'h0, mode[i][2], 1'b0, mode[i][1], 2'h0});
            wr(3'h0, 8'h02);
            period(1'b1, n);
            cmp_count(n, 3 * mult[i]);
            cmp_byte({7'h00, sync_mode_out}, {7'h00, mode[i][2]});
        end
        $display("test modes done");
    endtask

    // either divisor byte restarts a long count mid way
    task automatic test_restart;
        int n;
        logic [7:0] d;
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h00);
        wr(3'h0, 8'hc8);
        repeat (60) @(posedge clock_in);
        wr(3'h1, 8'h00);
        to_tick(1'b0, n);
        cmp_count(n, 202);
        wr(3'h0, 8'h02);
        to_tick(1'b0, n);
        cmp_count(n, 4);
        period(1'b0, n);
        cmp_count(n, 3);
        @(posedge clock_in);
        receiver_idle_in <= 1'b0;
        rd(3'h4, d);
        cmp_byte(d & 8'hc0, 8'h00);
        $display("test restart done");
    endtask

    // low enable freezes the count, holds pulses and ignores writes
    task automatic test_freeze;
        int n;
        logic [7:0] d;
        wr(3'h0, 8'h05);
        repeat (7) @(posedge clock_in);
        clock_enable_in <= 1'b0;
        wr(3'h0, 8'h01);
        repeat (4) @(posedge clock_in);
        #1 cmp_byte({7'h00, baud_tick_out}, 8'h01);
        @(posedge clock_in);
        clock_enable_in <= 1'b1;
        to_tick(1'b0, n);
        cmp_count(n, 6);
        to_tick(1'b0, n);
        cmp_count(n, 6);
        rd(3'h0, d);
        cmp_byte(d, 8'h05);
        $display("test freeze done");
    endtask

    task automatic results;
        $display("checked %0d, failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clock_in);
        reset_in <= 1'b0;
        test_reset();
        test_narrow();
        test_wide();
        test_modes();
        test_restart();
        test_freeze();
        results();
    end

    // whole run is a few thousand cycles; allow ample margin
    initial begin
        #(8 * 50000);
        failures++;
        results();
    end
endmodule

`default_nettype wire

// [verilog/baud_divider.sv]
// free-running divider timer: ticks once every divisor+1 enabled clocks
// assumes clear_in and divisor_in come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module baud_divider (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire logic clear_in,
    input wire logic wide_in,
    input wire logic [15:0] divisor_in,
    output logic tick_out,
    output logic [15:0] count_out
);

    baud_pkg::divider_state_t state;
    baud_pkg::divider_state_t next_state;
    logic [15:0] limit;

    // narrow mode uses only the low byte
    assign limit = wide_in ? divisor_in
                           : {baud_pkg::ZERO_BYTE, divisor_in[7:0]};

    always_comb begin
        next_state = state;
        if (enable_in) begin
            if (clear_in) begin
                next_state.count = baud_pkg::ZERO_COUNT;
                next_state.tick = 1'b0;
            // >= so a narrowed limit never lets the count run to wrap
            end else if (state.count >= limit) begin
                next_state.count = baud_pkg::ZERO_COUNT;
                next_state.tick = 1'b1;
            end else begin
                next_state.count = state.count + baud_pkg::ONE_COUNT;
                next_state.tick = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick_out = state.tick;
    assign count_out = state.count;

    chk_tick_at_limit: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && !clear_in && state.count == limit
        |=> state.tick && state.count == baud_pkg::ZERO_COUNT)
        else $error("divider missed its reload tick");

    chk_clear_restarts: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && clear_in |=> state.count == baud_pkg::ZERO_COUNT && !state.tick)
        else $error("divider not cleared by divisor write");

    chk_count_steps: assert property (@(posedge clock_in) disable iff (reset_in)
        enable_in && !clear_in && state.count < limit
        |=> state.count == $past(state.count) + baud_pkg::ONE_COUNT && !state.tick)
        else $error("divider did not count up by one");

    chk_frozen_hold: assert property (@(posedge clock_in) disable iff (reset_in)
        !enable_in |=> $stable(state.count) && $stable(state.tick))
        else $error("divider moved while clock enable low");

endmodule

`default_nettype wire

// [verilog/baud_pkg.sv]
// constants, field layouts and state carriers of the baud rate generator
// assumes one 125 MHz clock; register port is 8 bits wide, 3-bit address
//
// Behaviour
// - one divider timer, 8 or 16 bits wide, times async and sync serial.
// - after reset the divider is 8 bits; wide select makes it 16 bits.
// - divisor high and low bytes set the free-running divider period.
// - async multiplier comes from high-speed select and wide select.
// - in synchronous mode the high-speed select bit is ignored.
// - writing either divisor byte clears the divider timer at once.
// - async, 8-bit, standard speed: baud is clock over 64 times divisor+1.
`default_nettype none

package baud_pkg;

    localparam int CLOCK_HZ = 125000000;
    localparam int DIV_WIDTH = 16;
    localparam int BYTE_WIDTH = 8;
    localparam int ADDR_WIDTH = 3;
    localparam int PRESCALE_WIDTH = 6;

    // register map, one byte per address
    localparam logic [2:0] ADDR_DIVISOR_LOW = 3'h0;
    localparam logic [2:0] ADDR_DIVISOR_HIGH = 3'h1;
    localparam logic [2:0] ADDR_BAUD_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_TX_STATUS_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;

    // field positions
    localparam int WIDE_BIT = 3;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int SYNC_MODE_BIT = 4;
    localparam int IDLE_BIT = 7;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ZERO_COUNT = 16'h0000;
    localparam logic [15:0] ONE_COUNT = 16'h0001;
    localparam logic [5:0] ZERO_PRESCALE = 6'h00;
    localparam logic [5:0] ONE_PRESCALE = 6'h01;

    // period multiplier minus one, per mode
    localparam logic [5:0] LIMIT_X64 = 6'h3f;
    localparam logic [5:0] LIMIT_X16 = 6'h0f;
    localparam logic [5:0] LIMIT_X4 = 6'h03;

    typedef struct packed {
        logic [7:0] divisor_high_byte;
        logic [7:0] divisor_low_byte;
        logic wide_counter_select;
        logic high_speed_select;
        logic sync_mode;
    } baud_regs_t;

    typedef struct packed {
        logic [15:0] count;
        logic tick;
    } divider_state_t;

    typedef struct packed {
        baud_regs_t regs;
        logic [7:0] read_data;
        logic [5:0] prescale;
        logic bit_tick;
        logic baud_tick;
        logic [5:0] limit;
    } baud_state_t;

endpackage

`default_nettype wire

// [verilog/baud_rate_generator.sv]
// baud rate generator: divisor registers, mode bits and multiplier prescale
// assumes a same-clock register master with one-cycle strobes
`timescale 1ns/1ps
`default_nettype none

module baud_rate_generator (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic clock_enable_in,
    input wire logic [2:0] address_in,
    input wire logic [7:0] write_data_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic receiver_idle_in,
    output logic [7:0] read_data_out,
    output logic baud_tick_out,
    output logic bit_tick_out,
    output logic wide_counter_out,
    output logic sync_mode_out
);

    baud_pkg::baud_state_t state;
    baud_pkg::baud_state_t next_state;
    logic divisor_write;
    logic divider_tick;
    logic [15:0] divider_count;
    logic [5:0] mode_limit;

    assign divisor_write = write_in &&
        (address_in == baud_pkg::ADDR_DIVISOR_LOW ||
         address_in == baud_pkg::ADDR_DIVISOR_HIGH);

    baud_divider divider (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .enable_in(clock_enable_in),
        .clear_in(divisor_write),
        .wide_in(state.regs.wide_counter_select),
        .divisor_in({state.regs.divisor_high_byte,
                     state.regs.divisor_low_byte}),
        .tick_out(divider_tick),
        .count_out(divider_count)
    );

    // multiplier per mode; sync ignores high speed
    always_comb begin
        if (state.regs.sync_mode) begin
            mode_limit = baud_pkg::LIMIT_X4;
        end else if (!state.regs.wide_counter_select &&
                     !state.regs.high_speed_select) begin
            mode_limit = baud_pkg::LIMIT_X64;
        end else if (state.regs.wide_counter_select &&
                     state.regs.high_speed_select) begin
            mode_limit = baud_pkg::LIMIT_X4;
        end else begin
            mode_limit = baud_pkg::LIMIT_X16;
        end
    end

    always_comb begin
        next_state = state;
        if (clock_enable_in) begin
            next_state.limit = mode_limit;
            next_state.baud_tick = divider_tick;
            next_state.bit_tick = 1'b0;
            // register writes
            if (write_in) begin
                if (address_in == baud_pkg::ADDR_DIVISOR_LOW) begin
                    next_state.regs.divisor_low_byte = write_data_in;
                end else if (address_in == baud_pkg::ADDR_DIVISOR_HIGH) begin
                    next_state.regs.divisor_high_byte = write_data_in;
                end else if (address_in == baud_pkg::ADDR_BAUD_CONTROL) begin
                    next_state.regs.wide_counter_select =
                        write_data_in[baud_pkg::WIDE_BIT];
                end else if (address_in == baud_pkg::ADDR_TX_STATUS_CONTROL) begin
                    next_state.regs.high_speed_select =
                        write_data_in[baud_pkg::HIGH_SPEED_BIT];
                    next_state.regs.sync_mode =
                        write_data_in[baud_pkg::SYNC_MODE_BIT];
                end
            end
            // reads answer one cycle later, zero otherwise
            next_state.read_data = baud_pkg::ZERO_BYTE;
            if (read_in) begin
                if (address_in == baud_pkg::ADDR_DIVISOR_LOW) begin
                    next_state.read_data = state.regs.divisor_low_byte;
                end else if (address_in == baud_pkg::ADDR_DIVISOR_HIGH) begin
                    next_state.read_data = state.regs.divisor_high_byte;
                end else if (address_in == baud_pkg::ADDR_BAUD_CONTROL) begin
                    next_state.read_data[baud_pkg::WIDE_BIT] =
                        state.regs.wide_counter_select;
                end else if (address_in == baud_pkg::ADDR_TX_STATUS_CONTROL) begin
                    next_state.read_data[baud_pkg::HIGH_SPEED_BIT] =
                        state.regs.high_speed_select;
                    next_state.read_data[baud_pkg::SYNC_MODE_BIT] =
                        state.regs.sync_mode;
                end else if (address_in == baud_pkg::ADDR_STATUS) begin
                    // idle flag lets software time a clock change
                    next_state.read_data[baud_pkg::IDLE_BIT] = receiver_idle_in;
                    next_state.read_data[5:0] = state.prescale;
                end
            end
            // prescale restarts with the divider so the new rate is clean
            if (divisor_write) begin
                next_state.prescale = baud_pkg::ZERO_PRESCALE;
            end else if (divider_tick) begin
                if (state.prescale >= mode_limit) begin
                    next_state.prescale = baud_pkg::ZERO_PRESCALE;
                    next_state.bit_tick = 1'b1;
                end else begin
                    next_state.prescale = state.prescale + baud_pkg::ONE_PRESCALE;
                end
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state <= '0; // divider starts narrow
            state.limit <= baud_pkg::LIMIT_X64;
        end else begin
            state <= next_state;
        end
    end

    assign read_data_out = state.read_data;
    assign baud_tick_out = state.baud_tick;
    assign bit_tick_out = state.bit_tick;
    assign wide_counter_out = state.regs.wide_counter_select;
    assign sync_mode_out = state.regs.sync_mode;

    sequence divisor_write_s;
        clock_enable_in && divisor_write;
    endsequence

    // count and prescale both restart and the divider tick is low the cycle after the write
    sequence divider_cleared_s;
        divider_count == baud_pkg::ZERO_COUNT && !divider_tick &&
        state.prescale == baud_pkg::ZERO_PRESCALE
        ##1 state.prescale == baud_pkg::ZERO_PRESCALE;
    endsequence

    chk_divisor_clears: assert property (@(posedge clock_in) disable iff (reset_in)
        divisor_write_s |=> divider_cleared_s)
        else $error("divisor write did not restart the timer");

    chk_width_select: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in && write_in && address_in == baud_pkg::ADDR_BAUD_CONTROL
        |=> wide_counter_out == $past(write_data_in[baud_pkg::WIDE_BIT]))
        else $error("wide counter select not stored");

    chk_sync_limit: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in && state.regs.sync_mode |=> state.limit == baud_pkg::LIMIT_X4)
        else $error("sync mode multiplier wrong");

    chk_slow_limit: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in && !state.regs.sync_mode && !state.regs.wide_counter_select
        && !state.regs.high_speed_select |=> state.limit == baud_pkg::LIMIT_X64)
        else $error("standard async multiplier is not 64");

    chk_bit_tick_cause: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in && divider_tick && !divisor_write
        && state.prescale == mode_limit |=> bit_tick_out)
        else $error("bit tick missing after full prescale");

    chk_bit_tick_only: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in && !divider_tick |=> !bit_tick_out)
        else $error("bit tick without divider tick");

    chk_baud_follows: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in |=> baud_tick_out == $past(divider_tick))
        else $error("baud tick does not follow divider");

    chk_read_window: assert property (@(posedge clock_in) disable iff (reset_in)
        clock_enable_in && !read_in |=> read_data_out == baud_pkg::ZERO_BYTE)
        else $error("read data outside its cycle");

endmodule

`default_nettype wire
